// ---- hw/bsc_pkg.sv ----
// bsc_pkg: constants, register map and state encodings for the bridge sideband block.
// assumes a single 125 MHz core clock and a plain address/strobe register port.
package bsc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEC_RESET_DELAY_US = 100;
    localparam int SEC_RESET_DELAY_CYCLES = (SEC_RESET_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int NUM_SEC_CLOCKS = 10;
    localparam int NUM_GPIO = 4;
    localparam int EJECTOR_PIN = 3;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int DELAY_WIDTH = 24;
    localparam int MASK_COUNT_WIDTH = 4;

    localparam logic [ADDR_WIDTH-1:0] ADDR_SEC_CLOCK_CTRL = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] ADDR_GPIO_OUT_ENABLE = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] ADDR_GPIO_OUT_DATA = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] ADDR_GPIO_IN_DATA = 8'h0c;
    localparam logic [ADDR_WIDTH-1:0] ADDR_HOT_SWAP_CTRL = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] ADDR_BRIDGE_CTRL = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STRAP_STATUS = 8'h18;

    // hot-swap control/status fields
    localparam int HOT_SWAP_INDICATOR_BIT = 3;
    localparam int HS_EVENT_BIT = 7;
    localparam int HS_ENABLED_BIT = 0;
    // bridge control fields
    localparam int BC_SEC_RESET_BIT = 6;
    localparam int BC_D3HOT_BIT = 0;
    // strap status fields
    localparam int ST_HIGH_SPEED_CAP_BIT = 0;
    localparam int ST_PRIMARY_66_BIT = 1;
    localparam int ST_SECONDARY_66_BIT = 2;
    localparam int ST_HALF_RATE_BIT = 3;
    localparam int ST_BUS_B2_BIT = 4;
    localparam int ST_SEC_RESET_BIT = 5;
    localparam int ST_MASK_DONE_BIT = 6;

    localparam logic [NUM_SEC_CLOCKS-1:0] SEC_CLOCK_MASK_RESET = 10'h000;
    localparam logic [NUM_GPIO-1:0] GPIO_RESET = 4'h0;
    localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        BSC_SHIFT_MASK = 2'b00,
        BSC_WAIT_DELAY = 2'b01,
        BSC_RUNNING = 2'b10
    } bsc_seq_type;
endpackage : bsc_pkg

// ---- hw/bsc_sideband.sv ----
// bsc_sideband: straps, secondary clock mask/gating, secondary reset, gpio and hot-swap logic.
// assumes all pins synchronous to core_clk; software reaches registers over a plain strobe port.
//
// Overview of operation
// R01 - shift clock mask only after primary reset
// R02 - captured mask lands in clock control register
// R03 - release secondary reset 100 us after masking
// R04 - mask low runs clocks, high drives high
// R05 - capability strap high reports 66 MHz
// R06 - primary speed select picks 66/33 MHz
// R07 - secondary speed sense is wired-OR input
// R08 - secondary 66 MHz only when sense high
// R09 - pull sense low in reset if primary slow
// R10 - power strap high: D3hot stops clocks low
// R11 - power strap low: D3hot leaves clocks alone
// R12 - four gpio with enable, data, input registers
// R13 - hot-swap mode: gpio 3 is ejector input
// R14 - ejector event drives enumeration alert low
// R15 - indicator follows software LED bit
// R16 - mode low 0, high 1: hot-swap on
// R17 - mode low 1: hot-swap off, gpio 3 normal
// R18 - half rate when sense low, primary fast
// R19 - secondary reset until mask done, bit clear
// R20 - ten mask bits, one disables output
// R21 - both modes 0: hot-swap off
// R22 - straps sampled during reset, then held
`timescale 1ns/1ns
module bsc_sideband
    import bsc_pkg::*;
#(
    parameter int RESET_DELAY_CYCLES = SEC_RESET_DELAY_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clock_mask_serial_in,
    input wire logic high_speed_capable_strap,
    input wire logic primary_speed_select,
    input wire logic secondary_speed_sense_in,
    output logic secondary_speed_sense_out,
    output logic secondary_speed_sense_oe,
    input wire logic bus_power_clock_control_strap,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic [NUM_GPIO-1:0] gpio_in,
    output logic [NUM_GPIO-1:0] gpio_out,
    output logic [NUM_GPIO-1:0] gpio_oe,
    output logic enumeration_alert_n,
    output logic hot_swap_indicator,
    output logic [NUM_SEC_CLOCKS-1:0] sec_clock_out,
    output logic sec_reset_n,
    output logic high_speed_capable,
    output logic primary_fast,
    output logic secondary_fast,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_WIDTH-1:0] reg_rdata
);
    bsc_seq_type seq_reg;
    logic [MASK_COUNT_WIDTH-1:0] mask_count_reg;
    logic [DELAY_WIDTH-1:0] delay_reg;
    logic [NUM_SEC_CLOCKS-1:0] clock_mask_reg;
    logic high_cap_reg;
    logic primary_fast_reg;
    logic bus_power_reg;
    logic mode_low_reg;
    logic mode_high_reg;
    logic secondary_fast_reg;
    logic [NUM_GPIO-1:0] gpio_oe_reg;
    logic [NUM_GPIO-1:0] gpio_data_reg;
    logic [NUM_GPIO-1:0] gpio_in_reg;
    logic led_reg;
    logic event_reg;
    logic edge_armed_reg;
    logic sec_reset_bit_reg;
    logic d3hot_reg;
    logic div_reg;
    logic clock_phase_reg;
    logic [NUM_SEC_CLOCKS-1:0] sec_clock_reg;
    logic sec_reset_reg;
    logic sense_drive_reg;
    logic [DATA_WIDTH-1:0] rdata_reg;
    logic hot_swap_on;
    logic half_rate;
    logic bus_b2;
    logic ejector_n;
    logic do_write_hs;

    function automatic logic [DATA_WIDTH-1:0] bsc_widen(input logic [NUM_SEC_CLOCKS-1:0] v);
        bsc_widen = {{(DATA_WIDTH-NUM_SEC_CLOCKS){1'b0}}, v};
    endfunction : bsc_widen

    // write strobe aimed at one register offset
    function automatic logic bsc_wr_hit(input logic wr, input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] target);
        bsc_wr_hit = wr && (addr == target);
    endfunction : bsc_wr_hit

    // hot-swap only with mode low 0 and mode high 1
    assign hot_swap_on = !mode_low_reg && mode_high_reg; // R16 R17 R21
    assign half_rate = primary_fast_reg && !secondary_fast_reg; // R18
    assign bus_b2 = bus_power_reg && d3hot_reg; // R10 R11
    assign ejector_n = gpio_in_reg[EJECTOR_PIN]; // R13
    assign do_write_hs = bsc_wr_hit(reg_write, reg_addr, ADDR_HOT_SWAP_CTRL);

    // straps follow their pins while reset is active and hold afterwards
    always_ff @(posedge core_clk) begin
        if (!nrst) begin // R22
            high_cap_reg <= high_speed_capable_strap; // R05
            primary_fast_reg <= primary_speed_select; // R06
            bus_power_reg <= bus_power_clock_control_strap;
            mode_low_reg <= mode_select_low;
            mode_high_reg <= mode_select_high;
        end
    end

    // secondary speed sense is sampled continuously as the wired-OR of all devices
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            secondary_fast_reg <= 1'b0;
        end else begin
            secondary_fast_reg <= secondary_speed_sense_in; // R07 R08
        end
    end

    // mask shift, then delay, then release of secondary reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seq_reg <= BSC_SHIFT_MASK;
            mask_count_reg <= '0;
            delay_reg <= '0;
            clock_mask_reg <= SEC_CLOCK_MASK_RESET;
        end else begin
            case (seq_reg)
                BSC_SHIFT_MASK: begin
                    clock_mask_reg <= {clock_mask_serial_in, clock_mask_reg[NUM_SEC_CLOCKS-1:1]}; // R01 R02 R20
                    if (mask_count_reg == MASK_COUNT_WIDTH'(NUM_SEC_CLOCKS - 1)) begin
                        seq_reg <= BSC_WAIT_DELAY;
                        delay_reg <= '0;
                    end else begin
                        mask_count_reg <= mask_count_reg + 1'b1;
                    end
                end
                BSC_WAIT_DELAY: begin
                    if (bsc_wr_hit(reg_write, reg_addr, ADDR_SEC_CLOCK_CTRL)) begin
                        clock_mask_reg <= reg_wdata[NUM_SEC_CLOCKS-1:0];
                    end
                    if (sec_reset_bit_reg) begin
                        delay_reg <= '0;
                    end else if (delay_reg == DELAY_WIDTH'(RESET_DELAY_CYCLES - 1)) begin
                        seq_reg <= BSC_RUNNING; // R03
                    end else begin
                        delay_reg <= delay_reg + 1'b1;
                    end
                end
                BSC_RUNNING: begin
                    if (bsc_wr_hit(reg_write, reg_addr, ADDR_SEC_CLOCK_CTRL)) begin
                        clock_mask_reg <= reg_wdata[NUM_SEC_CLOCKS-1:0]; // R02
                    end
                    if (sec_reset_bit_reg) begin
                        seq_reg <= BSC_WAIT_DELAY;
                        delay_reg <= '0;
                    end
                end
                default: begin
                    seq_reg <= BSC_SHIFT_MASK;
                end
            endcase
        end
    end

    // secondary reset output and speed-sense pull-down
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sec_reset_reg <= 1'b0;
            sense_drive_reg <= 1'b0;
        end else begin
            sec_reset_reg <= (seq_reg == BSC_RUNNING) && !sec_reset_bit_reg; // R19
            // pull only while the secondary bus is held in reset
            sense_drive_reg <= !primary_fast_reg && (seq_reg != BSC_RUNNING); // R09
        end
    end

    // secondary clock generation with per-output mask and bus power gating
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 1'b0;
            clock_phase_reg <= 1'b0;
            sec_clock_reg <= '0;
        end else begin
            div_reg <= !div_reg;
            if (!half_rate || div_reg) begin // R18
                clock_phase_reg <= !clock_phase_reg;
            end
            for (int i = 0; i < NUM_SEC_CLOCKS; i++) begin
                if (bus_b2) begin
                    sec_clock_reg[i] <= 1'b0; // R10
                end else if (clock_mask_reg[i] && seq_reg != BSC_SHIFT_MASK) begin
                    sec_clock_reg[i] <= 1'b1; // R04 R20
                end else begin
                    sec_clock_reg[i] <= clock_phase_reg; // R04 R11
                end
            end
        end
    end

    // gpio registers and pin drive
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_oe_reg <= GPIO_RESET;
            gpio_data_reg <= GPIO_RESET;
            gpio_in_reg <= GPIO_RESET;
        end else begin
            gpio_in_reg <= gpio_in; // R12
            if (bsc_wr_hit(reg_write, reg_addr, ADDR_GPIO_OUT_ENABLE)) begin
                gpio_oe_reg <= reg_wdata[NUM_GPIO-1:0]; // R12
            end
            if (bsc_wr_hit(reg_write, reg_addr, ADDR_GPIO_OUT_DATA)) begin
                gpio_data_reg <= reg_wdata[NUM_GPIO-1:0]; // R12
            end
        end
    end

    // pin samples hold their reset value for one cycle: no edge is trusted until then
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            edge_armed_reg <= 1'b0;
        end else begin
            edge_armed_reg <= 1'b1;
        end
    end

    // indicator bit written by software
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            led_reg <= 1'b0;
        end else if (do_write_hs) begin
            led_reg <= reg_wdata[HOT_SWAP_INDICATOR_BIT]; // R15
        end
    end

    // hot-swap event detect and alert flag
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            event_reg <= 1'b0;
        end else begin
            // an edge in the clearing cycle keeps the flag set
            if (hot_swap_on && edge_armed_reg && (gpio_in[EJECTOR_PIN] != ejector_n)) begin
                event_reg <= 1'b1; // R14
            end else if (do_write_hs && reg_wdata[HS_EVENT_BIT]) begin
                event_reg <= 1'b0;
            end
        end
    end

    // software control bits
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sec_reset_bit_reg <= 1'b0;
            d3hot_reg <= 1'b0;
        end else if (bsc_wr_hit(reg_write, reg_addr, ADDR_BRIDGE_CTRL)) begin
            sec_reset_bit_reg <= reg_wdata[BC_SEC_RESET_BIT]; // R19
            d3hot_reg <= reg_wdata[BC_D3HOT_BIT];
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= READ_ZERO;
        end else if (reg_read) begin
            rdata_reg <= READ_ZERO;
            if (reg_addr == ADDR_SEC_CLOCK_CTRL) begin
                rdata_reg <= bsc_widen(clock_mask_reg); // R02
            end else if (reg_addr == ADDR_GPIO_OUT_ENABLE) begin
                rdata_reg[NUM_GPIO-1:0] <= gpio_oe_reg;
            end else if (reg_addr == ADDR_GPIO_OUT_DATA) begin
                rdata_reg[NUM_GPIO-1:0] <= gpio_data_reg;
            end else if (reg_addr == ADDR_GPIO_IN_DATA) begin
                rdata_reg[NUM_GPIO-1:0] <= gpio_in_reg; // R12
            end else if (reg_addr == ADDR_HOT_SWAP_CTRL) begin
                rdata_reg[HS_ENABLED_BIT] <= hot_swap_on;
                rdata_reg[HOT_SWAP_INDICATOR_BIT] <= led_reg;
                rdata_reg[HS_EVENT_BIT] <= event_reg;
            end else if (reg_addr == ADDR_BRIDGE_CTRL) begin
                rdata_reg[BC_SEC_RESET_BIT] <= sec_reset_bit_reg;
                rdata_reg[BC_D3HOT_BIT] <= d3hot_reg;
            end else if (reg_addr == ADDR_STRAP_STATUS) begin
                rdata_reg[ST_HIGH_SPEED_CAP_BIT] <= high_cap_reg;
                rdata_reg[ST_PRIMARY_66_BIT] <= primary_fast_reg;
                rdata_reg[ST_SECONDARY_66_BIT] <= secondary_fast_reg;
                rdata_reg[ST_HALF_RATE_BIT] <= half_rate;
                rdata_reg[ST_BUS_B2_BIT] <= bus_b2;
                rdata_reg[ST_SEC_RESET_BIT] <= !sec_reset_reg;
                rdata_reg[ST_MASK_DONE_BIT] <= seq_reg != BSC_SHIFT_MASK;
            end
        end
    end

    // registered pin drivers
    logic [NUM_GPIO-1:0] gpio_out_q;
    logic [NUM_GPIO-1:0] gpio_oe_q;
    logic alert_q;
    logic led_q;
    logic cap_q;
    logic pfast_q;
    logic sfast_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            gpio_out_q <= GPIO_RESET;
            gpio_oe_q <= GPIO_RESET;
            alert_q <= 1'b1;
            led_q <= 1'b0;
            cap_q <= 1'b0;
            pfast_q <= 1'b0;
            sfast_q <= 1'b0;
        end else begin
            gpio_out_q <= gpio_data_reg;
            gpio_oe_q <= gpio_oe_reg;
            if (hot_swap_on) begin
                gpio_oe_q[EJECTOR_PIN] <= 1'b0; // R13 R16
            end
            alert_q <= !event_reg; // R14
            led_q <= led_reg; // R15
            cap_q <= high_cap_reg; // R05
            pfast_q <= primary_fast_reg; // R06
            sfast_q <= secondary_fast_reg; // R08
        end
    end

    assign gpio_out = gpio_out_q;
    assign gpio_oe = gpio_oe_q;
    assign enumeration_alert_n = alert_q;
    assign hot_swap_indicator = led_q;
    assign sec_clock_out = sec_clock_reg;
    assign sec_reset_n = sec_reset_reg;
    // open drain: the line is only ever pulled low, the enable decides when
    assign secondary_speed_sense_out = 1'b0;
    assign secondary_speed_sense_oe = sense_drive_reg;
    assign high_speed_capable = cap_q;
    assign primary_fast = pfast_q;
    assign secondary_fast = sfast_q;
    assign reg_rdata = rdata_reg;
endmodule : bsc_sideband

// ---- sim/bsc_asserts.sv ----
// bsc_asserts: port-level checks on the sideband block, bound into every instance
// assumes straps and mode inputs stay constant between primary resets
`timescale 1ns/1ns
module bsc_asserts
    import bsc_pkg::*;
#(
    parameter int RESET_DELAY_CYCLES = SEC_RESET_DELAY_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic [NUM_GPIO-1:0] gpio_in,
    input wire logic secondary_speed_sense_out,
    input wire logic secondary_speed_sense_oe,
    input wire logic enumeration_alert_n,
    input wire logic sec_reset_n,
    input wire logic high_speed_capable,
    input wire logic primary_fast
);
    logic [4:0] rel_cnt;
    logic [23:0] low_cnt;
    logic hot;
    assign hot = !mode_select_low && mode_select_high;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // edges since reset release and edges with secondary reset low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rel_cnt <= 5'h00;
            low_cnt <= 24'h000000;
        end else begin
            rel_cnt <= (rel_cnt == 5'h1f) ? rel_cnt : rel_cnt + 5'h01;
            low_cnt <= sec_reset_n ? 24'h000000 : low_cnt + 24'h000001;
        end
    end
    property p_sense_drain; secondary_speed_sense_out == 1'b0; endproperty
    a_sense_drain: assert property (p_sense_drain) else $error("sense line driven high");
    property p_pull_cause; secondary_speed_sense_oe |-> !primary_fast && !$past(sec_reset_n); endproperty
    a_pull_cause: assert property (p_pull_cause) else $error("sense pulled outside reset");
    property p_pull_held; rel_cnt inside {[5'h02:5'h0a]} && !primary_fast |-> secondary_speed_sense_oe; endproperty
    a_pull_held: assert property (p_pull_held) else $error("sense not pulled low");
    property p_strap_hold; rel_cnt >= 5'h03 |-> $stable(primary_fast) && $stable(high_speed_capable); endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap status moved");
    property p_mask_hold; rel_cnt <= 5'h0b |-> !sec_reset_n; endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("secondary reset left during shift");
    property p_release_delay; $rose(sec_reset_n) |-> low_cnt >= RESET_DELAY_CYCLES; endproperty
    a_release_delay: assert property (p_release_delay) else $error("secondary reset released early");
    property p_alert_mode; $fell(enumeration_alert_n) |-> hot; endproperty
    a_alert_mode: assert property (p_alert_mode) else $error("alert outside hot-swap mode");
    property p_alert_event;
        hot && rel_cnt >= 5'h03 && enumeration_alert_n && $changed(gpio_in[EJECTOR_PIN])
            |-> ##[1:4] !enumeration_alert_n;
    endproperty
    a_alert_event: assert property (p_alert_event) else $error("ejector event not signalled");
endmodule : bsc_asserts

bind bsc_sideband bsc_asserts #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
    .gpio_in(gpio_in), .secondary_speed_sense_out(secondary_speed_sense_out),
    .secondary_speed_sense_oe(secondary_speed_sense_oe), .enumeration_alert_n(enumeration_alert_n),
    .sec_reset_n(sec_reset_n), .high_speed_capable(high_speed_capable), .primary_fast(primary_fast));

// ---- sim/bsc_partner.sv ----
// bsc_partner: serial mask source, wired-or speed line, gpio pins and ejector switch
// assumes the bench sets the mask word while nrst is low; pin levels may change at any time
`timescale 1ns/1ns
module bsc_partner
    import bsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [NUM_SEC_CLOCKS-1:0] mask_word,
    input wire logic devs_fast,
    input wire logic [NUM_GPIO-1:0] pin_level,
    input wire logic sense_oe,
    input wire logic [NUM_GPIO-1:0] gpio_out,
    input wire logic [NUM_GPIO-1:0] gpio_oe,
    output logic clock_mask_serial_in,
    output logic sense_line,
    output logic [NUM_GPIO-1:0] gpio_in
);
    logic [3:0] bit_idx;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) bit_idx <= 4'h0;
        else if (bit_idx != 4'ha) bit_idx <= bit_idx + 4'h1;
    end
    // lsb first from the first edge after release, then the tie level stays
    assign clock_mask_serial_in = (bit_idx < 4'ha) ? mask_word[bit_idx] : mask_word[9];
    // pull-up, slow devices and the bridge pull low
    assign sense_line = devs_fast & ~sense_oe;
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_level);
endmodule : bsc_partner

// ---- sim/bsc_sideband_tb_top.sv ----
// bsc_sideband_tb_top: register-driven tests of the sideband block with a board model
// assumes a 125 MHz core clock and a shortened secondary reset delay
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module bsc_sideband_tb_top;
    import bsc_pkg::*;
    localparam int DLY = 20;
    int err_count = 0;
    int total_checks = 0;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic cap = 1'b0, prim = 1'b0, pwr = 1'b0, ml = 1'b1, mh = 1'b0, devs_fast = 1'b0;
    logic [NUM_SEC_CLOCKS-1:0] mask_word = 10'h000;
    logic [NUM_GPIO-1:0] pin_level = 4'ha;
    logic [ADDR_WIDTH-1:0] reg_addr = 8'h00;
    logic [DATA_WIDTH-1:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic mask_in, sense, sense_oe, alert_n, led, sec_reset_n, hs_cap, p_fast, s_fast;
    logic [NUM_GPIO-1:0] gpio_in, gpio_out, gpio_oe;
    logic [NUM_SEC_CLOCKS-1:0] sclk;
    logic [DATA_WIDTH-1:0] reg_rdata;
    bsc_sideband #(.RESET_DELAY_CYCLES(DLY)) DUT (
        .core_clk(core_clk), .nrst(nrst), .clock_mask_serial_in(mask_in), .high_speed_capable_strap(cap),
        .primary_speed_select(prim), .secondary_speed_sense_in(sense), .secondary_speed_sense_out(),
        .secondary_speed_sense_oe(sense_oe), .bus_power_clock_control_strap(pwr), .mode_select_low(ml),
        .mode_select_high(mh), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .enumeration_alert_n(alert_n), .hot_swap_indicator(led), .sec_clock_out(sclk), .sec_reset_n(sec_reset_n),
        .high_speed_capable(hs_cap), .primary_fast(p_fast), .secondary_fast(s_fast), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    bsc_partner u_board (.core_clk(core_clk), .nrst(nrst), .mask_word(mask_word), .devs_fast(devs_fast),
        .pin_level(pin_level), .sense_oe(sense_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .clock_mask_serial_in(mask_in), .sense_line(sense), .gpio_in(gpio_in));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic start(input logic [NUM_SEC_CLOCKS-1:0] m, input logic [5:0] s);
        @(posedge core_clk);
        nrst <= 1'b0;
        {cap, prim, pwr, ml, mh, devs_fast} <= s;
        mask_word <= m;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
    endtask : start
    task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] m, input logic [DATA_WIDTH-1:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata & m, e)
    endtask : rd
    task automatic wait_rel(input int lo);
        int n;
        n = 0;
        while (sec_reset_n !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK({n >= lo, sec_reset_n}, 2'b11)
    endtask : wait_rel
    // run marks outputs expected to toggle, lvl the level of the rest
    task automatic clk_chk(input logic [NUM_SEC_CLOCKS-1:0] run, input logic [NUM_SEC_CLOCKS-1:0] lvl);
        logic [NUM_SEC_CLOCKS-1:0] chg, prev;
        chg = 10'h000;
        repeat (2) @(posedge core_clk);
        #1 prev = sclk;
        repeat (8) begin
            @(posedge core_clk);
            #1 chg = chg | (prev ^ sclk);
            prev = sclk;
        end
        `CHK(chg, run)
        `CHK(sclk & ~run, lvl)
    endtask : clk_chk
    task automatic eject(input logic [NUM_GPIO-1:0] lvl, input logic exp);
        @(posedge core_clk);
        pin_level <= lvl;
        repeat (6) @(posedge core_clk);
        #1 `CHK(alert_n, exp)
    endtask : eject
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        give_verdict();
    end
    initial begin
        start(10'h2a5, 6'b101011);
        repeat (2) @(posedge core_clk);
        #1 `CHK(sense_oe, 1'b1)
        wait_rel(9 + DLY);
        rd(ADDR_SEC_CLOCK_CTRL, 32'h3ff, 32'h2a5);
        clk_chk(10'h15a, 10'h2a5);
        `CHK({hs_cap, p_fast, s_fast, sense_oe}, 4'b1010)
        rd(ADDR_STRAP_STATUS, 32'h7f, 32'h45);
        wr(ADDR_SEC_CLOCK_CTRL, 32'h0f0);
        clk_chk(10'h30f, 10'h0f0);
        rd(ADDR_HOT_SWAP_CTRL, 32'h81, 32'h01);
        wr(ADDR_GPIO_OUT_ENABLE, 32'h8);
        #17 `CHK(gpio_oe, 4'h0)
        eject(4'h2, 1'b0);
        rd(ADDR_HOT_SWAP_CTRL, 32'h80, 32'h80);
        wr(ADDR_HOT_SWAP_CTRL, 32'h80);
        #25 `CHK(alert_n, 1'b1)
        wr(ADDR_HOT_SWAP_CTRL, 32'h08);
        #17 `CHK(led, 1'b1)
        wr(ADDR_HOT_SWAP_CTRL, 32'h00);
        #17 `CHK(led, 1'b0)
        wr(ADDR_BRIDGE_CTRL, 32'h1);
        clk_chk(10'h000, 10'h000);
        rd(ADDR_STRAP_STATUS, 32'h10, 32'h10);
        wr(ADDR_BRIDGE_CTRL, 32'h40);
        #17 `CHK(sec_reset_n, 1'b0)
        wr(ADDR_BRIDGE_CTRL, 32'h0);
        wait_rel(DLY);
        rd(8'h20, 32'hffff_ffff, 32'h0);
        start(10'h000, 6'b010100);
        repeat (2) @(posedge core_clk);
        #1 `CHK(sense_oe, 1'b0)
        wait_rel(9 + DLY);
        clk_chk(10'h3ff, 10'h000);
        `CHK({hs_cap, p_fast, s_fast}, 3'b010)
        rd(ADDR_STRAP_STATUS, 32'h0f, 32'h0a);
        wr(ADDR_BRIDGE_CTRL, 32'h1);
        clk_chk(10'h3ff, 10'h000);
        rd(ADDR_HOT_SWAP_CTRL, 32'h1, 32'h0);
        wr(ADDR_GPIO_OUT_ENABLE, 32'h5);
        wr(ADDR_GPIO_OUT_DATA, 32'h1);
        #17 `CHK({gpio_oe, gpio_out}, 8'h51)
        rd(ADDR_GPIO_IN_DATA, 32'hf, 32'h3);
        eject(4'ha, 1'b1);
        rd(ADDR_GPIO_IN_DATA, 32'hf, 32'hb);
        start(10'h3ff, 6'b100001);
        wait_rel(10 + DLY);
        clk_chk(10'h000, 10'h3ff);
        eject(4'h2, 1'b1);
        rd(ADDR_HOT_SWAP_CTRL, 32'h1, 32'h0);
        give_verdict();
    end
endmodule : bsc_sideband_tb_top
